/* src/pgw_port_ctrl.sv */
// Purpose: GPIO ports A to G: direction, pull-high, supply, slew and wake-up detection.
// Assumes: One 20 MHz core_clk, sys_rst asynchronous active high, classic Wishbone slave.
// Notes:   Pin inputs pass two flip-flops before any logic reads them.
`timescale 1ns/1ps
`default_nettype none
`include "pgw_regs.svh"

module pgw_port_ctrl (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic [55:0] pin_in,
  output logic      [55:0] pin_out,
  output logic      [55:0] pin_oe,
  output logic      [55:0] pin_pullup,
  input  wire logic [55:0] pin_is_gpio,
  input  wire logic [55:0] pin_is_nmos,
  input  wire logic        power_down,
  output logic             wake_req,
  output logic      [3:0]  porta_supply,
  output logic      [7:0]  slew_ab,
  output logic      [7:0]  slew_cd,
  output logic      [7:0]  slew_ef,
  output logic      [3:0]  slew_g
);

  localparam int NPIN = `PGW_NPORT * 8;

  logic [NPIN-1:0] out_latch;
  logic [NPIN-1:0] direction_regs;
  logic [NPIN-1:0] pullup_enable_regs;
  logic [NPIN-1:0] wake_enable_regs;
  logic [7:0]      porta_wake_edge_low;
  logic [7:0]      porta_wake_edge_high;
  logic [3:0]      porta_supply_select;
  logic [7:0]      slew_select_ab;
  logic [7:0]      slew_select_cd;
  logic [7:0]      slew_select_ef;
  logic [3:0]      slew_select_g;
  logic [NPIN-1:0] pin_sync;
  logic            wake_seen;
  logic [NPIN-1:0] pin_mask;
  logic [NPIN-1:0] next_wake_hit;
  logic [15:0]     porta_edge;
  logic            wr_stb;
  logic            rd_hit;
  logic [7:0]      next_rd;
  logic [2:0]      port_idx;
  logic [3:0]      port_ofs;
  logic            port_area;
  pgw_pkg::pgw_bus_e bus_state;

  assign porta_edge = {porta_wake_edge_high, porta_wake_edge_low};
  assign pin_mask   = {16'hffff, `PGW_PORTE_MASK, 32'hffffffff};
  assign port_idx   = wb_adr_i[6:4];
  assign port_ofs   = wb_adr_i[3:0];
  assign port_area  = (wb_adr_i[7] == 1'b0) && (port_idx < 3'd7);
  assign wr_stb     = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && (bus_state == pgw_pkg::PGW_BUS_IDLE);

  // Address decode; unmapped addresses answer with err instead of ack.
  always_comb begin
    rd_hit  = 1'b1;
    next_rd = `PGW_RESET_BYTE;
    if (port_area) begin
      case (port_ofs)
        4'h0: next_rd = ((direction_regs[port_idx*8 +: 8] & pin_sync[port_idx*8 +: 8]) |
                         (~direction_regs[port_idx*8 +: 8] & out_latch[port_idx*8 +: 8]))
                        & pin_mask[port_idx*8 +: 8];
        4'h4: next_rd = direction_regs[port_idx*8 +: 8];
        4'h8: next_rd = pullup_enable_regs[port_idx*8 +: 8];
        4'hc: next_rd = wake_enable_regs[port_idx*8 +: 8];
        default: rd_hit = 1'b0;
      endcase
    end else begin
      case (wb_adr_i)
        `PGW_OFS_WEDGE_LO: next_rd = porta_wake_edge_low;
        `PGW_OFS_WEDGE_HI: next_rd = porta_wake_edge_high;
        `PGW_OFS_SUPPLY:   next_rd = {4'h0, porta_supply_select};
        `PGW_OFS_SLEW_AB:  next_rd = slew_select_ab;
        `PGW_OFS_SLEW_CD:  next_rd = slew_select_cd;
        `PGW_OFS_SLEW_EF:  next_rd = slew_select_ef;
        `PGW_OFS_SLEW_G:   next_rd = {4'h0, slew_select_g};
        `PGW_OFS_STATUS:   next_rd = {7'h00, wake_seen};
        default:           rd_hit = 1'b0;
      endcase
    end
  end

  // One answer per request; the ack drops in the cycle after it is given.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_state <= pgw_pkg::PGW_BUS_IDLE;
      wb_ack_o  <= 1'b0;
      wb_err_o  <= 1'b0;
      wb_dat_o  <= 32'h0;
    end else begin
      case (bus_state)
        pgw_pkg::PGW_BUS_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            bus_state <= pgw_pkg::PGW_BUS_ACK;
            wb_ack_o  <= rd_hit;
            wb_err_o  <= !rd_hit;
            wb_dat_o  <= {24'h0, next_rd};
          end
        end
        pgw_pkg::PGW_BUS_ACK: begin
          bus_state <= pgw_pkg::PGW_BUS_IDLE;
          wb_ack_o  <= 1'b0;
          wb_err_o  <= 1'b0;
        end
        default: bus_state <= pgw_pkg::PGW_BUS_IDLE;
      endcase
    end
  end

  // Output latch; it holds its value until software writes the port again.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_latch <= '0;
    end else if (wr_stb && port_area && (port_ofs == 4'h0)) begin
      out_latch[port_idx*8 +: 8] <= wb_dat_i[7:0] & pin_mask[port_idx*8 +: 8];
    end
  end

  // Direction bits; a write lands at once, but pin_oe takes the change one cycle later.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      direction_regs <= '0;
    end else if (wr_stb && port_area && (port_ofs == 4'h4)) begin
      direction_regs[port_idx*8 +: 8] <= wb_dat_i[7:0] & pin_mask[port_idx*8 +: 8];
    end
  end

  // Pull-high enable bits, one per pin.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pullup_enable_regs <= '0;
    end else if (wr_stb && port_area && (port_ofs == 4'h8)) begin
      pullup_enable_regs[port_idx*8 +: 8] <= wb_dat_i[7:0] & pin_mask[port_idx*8 +: 8];
    end
  end

  // Wake enable bits; the Port A byte is stored but its pins use the edge codes instead.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_enable_regs <= '0;
    end else if (wr_stb && port_area && (port_ofs == 4'hc)) begin
      wake_enable_regs[port_idx*8 +: 8] <= wb_dat_i[7:0] & pin_mask[port_idx*8 +: 8];
    end
  end

  // Port A wake edge codes.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      porta_wake_edge_low  <= `PGW_RESET_BYTE;
      porta_wake_edge_high <= `PGW_RESET_BYTE;
    end else if (wr_stb && (wb_adr_i == `PGW_OFS_WEDGE_LO)) begin
      porta_wake_edge_low <= wb_dat_i[7:0];
    end else if (wr_stb && (wb_adr_i == `PGW_OFS_WEDGE_HI)) begin
      porta_wake_edge_high <= wb_dat_i[7:0];
    end
  end

  // Port A supply select; only four bits exist, so the upper nibble cannot be set.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      porta_supply_select <= 4'h0;
    end else if (wr_stb && (wb_adr_i == `PGW_OFS_SUPPLY)) begin
      porta_supply_select <= wb_dat_i[3:0];
    end
  end

  // Slew selects, two bits per nibble of pins.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slew_select_ab <= `PGW_RESET_BYTE;
      slew_select_cd <= `PGW_RESET_BYTE;
      slew_select_ef <= `PGW_RESET_BYTE;
      slew_select_g  <= 4'h0;
    end else if (wr_stb) begin
      case (wb_adr_i)
        `PGW_OFS_SLEW_AB: slew_select_ab <= wb_dat_i[7:0];
        `PGW_OFS_SLEW_CD: slew_select_cd <= wb_dat_i[7:0];
        `PGW_OFS_SLEW_EF: slew_select_ef <= wb_dat_i[7:0];
        `PGW_OFS_SLEW_G:  slew_select_g  <= wb_dat_i[3:0];
        default: ;
      endcase
    end
  end

  // One wake cell per pin; Port A takes its edge code, the other ports wake on falling only.
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    logic [1:0] edge_sel;
    if (i < 8) begin : g_porta
      assign edge_sel = porta_edge[i*2 +: 2];
    end else begin : g_other
      assign edge_sel = wake_enable_regs[i] ? `PGW_EDGE_FALL : `PGW_EDGE_OFF;
    end
    pgw_wake_cell u_cell (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .pin_raw   (pin_in[i]),
      .edge_sel  (edge_sel),
      .armed     (pin_is_gpio[i] & pin_mask[i] & power_down),
      .pin_level (pin_sync[i]),
      .hit       (next_wake_hit[i])
    );
  end

  // Wake request is a one-cycle pulse per transition.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= |next_wake_hit;
    end
  end

  // Sticky record for software; a new wake wins over a clear in the same cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_seen <= 1'b0;
    end else if (|next_wake_hit) begin
      wake_seen <= 1'b1;
    end else if (wr_stb && (wb_adr_i == `PGW_OFS_STATUS) && wb_dat_i[0]) begin
      wake_seen <= 1'b0;
    end
  end

  // Output data; the latch drives the pad even while the pin is an input.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out <= '0;
    end else begin
      pin_out <= out_latch;
    end
  end

  // Output enable is high while the pin is driven.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= ~direction_regs & pin_mask;
    end
  end

  // Pull-ups apply only to input or open-drain functions.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_pullup <= '0;
    end else begin
      pin_pullup <= pullup_enable_regs & (direction_regs | pin_is_nmos) & pin_mask;
    end
  end

  // Pad configuration copies, one cycle behind the registers.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      porta_supply <= 4'h0;
      slew_ab      <= 8'h00;
      slew_cd      <= 8'h00;
      slew_ef      <= 8'h00;
      slew_g       <= 4'h0;
    end else begin
      porta_supply <= porta_supply_select;
      slew_ab      <= slew_select_ab;
      slew_cd      <= slew_select_cd;
      slew_ef      <= slew_select_ef;
      slew_g       <= slew_select_g;
    end
  end

endmodule : pgw_port_ctrl

// Synchroniser and edge detector of one pin. The level after reset is low, so a pin that idles
// high shows one rising edge after reset; it is harmless because every pin's edge_sel is off after reset.
module pgw_wake_cell (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       pin_raw,
  input  wire logic [1:0] edge_sel,
  input  wire logic       armed,
  output logic            pin_level,
  output logic            hit
);

  logic pin_meta;
  logic pin_prev;

  // First stage may go metastable, so nothing but the second stage reads it.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta <= 1'b0;
    end else begin
      pin_meta <= pin_raw;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_level <= 1'b0;
    end else begin
      pin_level <= pin_meta;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_level;
    end
  end

  always_comb begin
    case (edge_sel)
      `PGW_EDGE_RISE: hit = armed & pin_level & ~pin_prev;
      `PGW_EDGE_FALL: hit = armed & ~pin_level & pin_prev;
      `PGW_EDGE_BOTH: hit = armed & (pin_level ^ pin_prev);
      default:        hit = 1'b0;
    endcase
  end

endmodule : pgw_wake_cell
`default_nettype wire

/* src/pgw_regs.svh */
// Purpose: Register map and field constants of the port pin configuration and wake-up block.
// Assumes: Classic Wishbone slave with 32-bit data, one aligned word per register.
// Notes:   Byte addresses; data sits in bits 7:0 and the bits above read as zero.
`ifndef PGW_REGS_SVH
`define PGW_REGS_SVH

`define PGW_NPORT          7
`define PGW_ADDR_W         8
// Per-port register groups: data, direction, pull-high, wake enable; port index times stride.
`define PGW_PORT_STRIDE    8'h10
`define PGW_OFS_DATA       8'h00
`define PGW_OFS_DIR        8'h04
`define PGW_OFS_PULL       8'h08
`define PGW_OFS_WAKE       8'h0c
`define PGW_OFS_WEDGE_LO   8'h80
`define PGW_OFS_WEDGE_HI   8'h84
`define PGW_OFS_SUPPLY     8'h88
`define PGW_OFS_SLEW_AB    8'h8c
`define PGW_OFS_SLEW_CD    8'h90
`define PGW_OFS_SLEW_EF    8'h94
`define PGW_OFS_SLEW_G     8'h98
`define PGW_OFS_STATUS     8'h9c
`define PGW_SUPPLY_MASK    8'h0f
`define PGW_SLEW_G_MASK    8'h0f
// Port E has no pin 1.
`define PGW_PORTE_MASK     8'hfd
`define PGW_EDGE_OFF       2'b00
`define PGW_EDGE_RISE      2'b01
`define PGW_EDGE_FALL      2'b10
`define PGW_EDGE_BOTH      2'b11
`define PGW_RESET_BYTE     8'h00

`endif

/* src/pgw_pkg.sv */
// Purpose: Types shared by the port pin configuration and wake-up block.
// Assumes: Nothing beyond the register header.
// Notes:   Types only; numbers live in the header.
package pgw_pkg;
  typedef logic [7:0] pgw_byte_t;
  typedef enum logic [1:0] {
    PGW_BUS_IDLE,
    PGW_BUS_ACK
  } pgw_bus_e;
endpackage : pgw_pkg

/* tb/pgw_pins_model.sv */
// Purpose: External switches and pull-ups seen at the port pins.
// Assumes: The bench sets which pins a switch holds and at what level.
// Notes:   A pin with no driver and no pull-up toggles every cycle.
`timescale 1ns/1ps
`default_nettype none
module pgw_pins_model (
  input  wire logic        core_clk,
  input  wire logic [55:0] pin_out,
  input  wire logic [55:0] pin_oe,
  input  wire logic [55:0] pin_pullup,
  input  wire logic [55:0] sw_en,
  input  wire logic [55:0] sw_val,
  output logic      [55:0] pin_in
);
  logic [55:0] flt = 56'h0;
  // A floating pin must never pass for a steady level, so it keeps changing.
  always @(posedge core_clk) flt <= ~flt;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & sw_en & sw_val) | (~pin_oe & ~sw_en & (pin_pullup | flt));
endmodule : pgw_pins_model
`default_nettype wire

/* tb/pgw_port_ctrl_chk.sv */
// Purpose: Assertions on the bus answer, pin outputs and wake pulse.
// Assumes: One clock domain; reset is asynchronous, active high.
// Notes:   Register outputs may lag a write by one cycle.
`timescale 1ns/1ps
`default_nettype none
module pgw_port_ctrl_chk (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [55:0] pin_out,
  input wire logic [55:0] pin_oe,
  input wire logic [55:0] pin_pullup,
  input wire logic [55:0] pin_is_nmos,
  input wire logic        power_down,
  input wire logic        wake_req,
  input wire logic [3:0]  porta_supply,
  input wire logic [7:0]  slew_ab
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_ans; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o; endproperty
  a_ans: assert property (p_ans) else $error("bus request not answered");
  property p_dir; wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h04 |=> pin_oe[7:0] == ~$past(wb_dat_i[7:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_lat; wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h30 |=> pin_out[31:24] == $past(wb_dat_i[7:0]);
  endproperty
  a_lat: assert property (p_lat) else $error("output latch wrong");
  property p_sup; wb_ack_o && !wb_we_i && wb_adr_i == 8'h88 |-> wb_dat_o[31:4] == 28'h0; endproperty
  a_sup: assert property (p_sup) else $error("supply upper bits not zero");
  property p_rst; disable iff (1'b0) sys_rst |=> porta_supply == 4'h0 && slew_ab == 8'h00 && !wake_req; endproperty
  a_rst: assert property (p_rst) else $error("config not cleared by reset");
  property p_wpd; wake_req |-> $past(power_down); endproperty
  a_wpd: assert property (p_wpd) else $error("wake outside power down");
  property p_one; wake_req |=> !wake_req; endproperty
  a_one: assert property (p_one) else $error("wake pulse too long");
  property p_pul; (pin_pullup & pin_oe & ~pin_is_nmos & ~$past(pin_is_nmos)) == 56'h0; endproperty
  a_pul: assert property (p_pul) else $error("pull-up on driven pin");
  c_wake: cover property (wake_req);
  c_err: cover property (wb_err_o);
  c_wr: cover property (wb_ack_o && wb_we_i);
endmodule : pgw_port_ctrl_chk
bind pgw_port_ctrl pgw_port_ctrl_chk chk (.core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .pin_out, .pin_oe, .pin_pullup, .pin_is_nmos,
  .power_down, .wake_req, .porta_supply, .slew_ab);
`default_nettype wire

/* tb/pgw_port_ctrl_test.sv */
// Purpose: Self-checking bench of the port configuration and wake block.
// Assumes: Bus answers in one cycle; pins pass two sync stages.
// Notes:   Table rows are write, address, data and expected read.
`timescale 1ns/1ps
`default_nettype none
module pgw_port_ctrl_test;
  logic        core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, power_down, wake_req, e;
  logic [7:0]  wb_adr_i, slew_ab;
  logic [3:0]  wb_sel_i, porta_supply, slew_g;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [55:0] pin_in, pin_out, pin_oe, pin_pullup, pin_is_gpio, pin_is_nmos, sw_en, sw_val;
  int          fails, comparisons;
  logic [31:0] rows [12] = '{32'h00_88_00_00, 32'h00_8c_00_00, 32'h00_80_00_00, 32'h01_80_1b_1b,
    32'h01_84_e4_e4, 32'h01_88_ff_0f, 32'h01_8c_e4_e4, 32'h01_98_ff_0f, 32'h01_44_ff_fd,
    32'h01_04_21_21, 32'h01_30_5a_5a, 32'h01_1c_01_01};
  pgw_port_ctrl dut (.core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_is_gpio, .pin_is_nmos,
    .power_down, .wake_req, .porta_supply, .slew_ab, .slew_cd(), .slew_ef(), .slew_g);
  pgw_pins_model pins (.core_clk, .pin_out, .pin_oe, .pin_pullup, .sw_en, .sw_val, .pin_in);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string nm);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      fails++;
      print_verdict;
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    wb(1'b0, a, 8'h00);
    chk({24'h0, x}, q, "read data");
  endtask : rd
  // Counts pulses so that a doubled wake request is caught as well.
  task automatic wk(input int b, input logic v, input logic x);
    int c;
    @(posedge core_clk);
    sw_val[b] <= v;
    c = 0;
    repeat (6) begin
      @(posedge core_clk);
      c += int'(wake_req === 1'b1);
    end
    chk({31'h0, x}, c, "wake pulses");
  endtask : wk
  initial begin
    {sys_rst, sw_en, sw_val, pin_is_gpio} = '1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, pin_is_nmos, power_down, fails, comparisons} = '0;
    wb_sel_i = 4'h1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][24]) wb(1'b1, rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk({28'h0, porta_supply}, 32'hf, "supply out");
    chk({24'h0, slew_ab}, 32'he4, "slew ab out");
    wb(1'b1, 8'h10, 8'h0e);
    wb(1'b1, 8'h14, 8'hff);
    sw_val[15:8] <= 8'h97;
    repeat (3) @(posedge core_clk);
    rd(8'h10, 8'h97);
    chk({24'h0, pin_oe[15:8]}, 32'h0, "oe b");
    wb(1'b1, 8'h14, 8'hfe);
    rd(8'h10, 8'h96);
    chk({24'h0, pin_oe[15:8]}, 32'h01, "oe b");
    sw_en[23:16] <= 8'h00;
    wb(1'b1, 8'h24, 8'hff);
    wb(1'b1, 8'h28, 8'hff);
    repeat (3) @(posedge core_clk);
    rd(8'h20, 8'hff);
    chk({24'h0, pin_pullup[23:16]}, 32'hff, "pullup c");
    wb(1'b1, 8'h24, 8'h00);
    pin_is_nmos[16] <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({24'h0, pin_pullup[23:16]}, 32'h01, "pullup c");
    rd(8'h30, 8'h5a);
    wb(1'b1, 8'h14, 8'hff);
    repeat (4) @(posedge core_clk);
    power_down <= 1'b1;
    wk(8, 1'b0, 1'b1);
    wk(8, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 8'h80, 8'(k));
      wk(0, 1'b0, k[1]);
      wk(0, 1'b1, k[0]);
    end
    wk(5, 1'b0, 1'b0);
    wk(5, 1'b1, 1'b1);
    wb(1'b1, 8'h1c, 8'h00);
    wk(8, 1'b0, 1'b0);
    wb(1'b1, 8'h1c, 8'h01);
    wk(8, 1'b1, 1'b0);
    power_down <= 1'b0;
    wk(8, 1'b0, 1'b0);
    power_down <= 1'b1;
    pin_is_gpio[8] <= 1'b0;
    wk(8, 1'b1, 1'b0);
    wk(8, 1'b0, 1'b0);
    rd(8'h9c, 8'h01);
    wb(1'b1, 8'h9c, 8'h01);
    rd(8'h9c, 8'h00);
    wb(1'b0, 8'hfc, 8'h00);
    chk({31'h0, e}, 32'h1, "bus error");
    print_verdict;
  end
endmodule : pgw_port_ctrl_test
`default_nettype wire
